// >>> logic/acrc_pkg.sv
// Shared constants and types of the converter configuration control block.
// Assumes a 25 MHz system clock and a 24-bit configuration word.
package acrc_pkg;

    localparam int          CFG_W       = 24;
    localparam logic [23:0] CFG_RESET   = 24'h000040;
    localparam logic [23:0] OFFS_RESET  = 24'h000000;
    localparam logic [23:0] GAIN_RESET  = 24'h400000;
    localparam logic [23:0] SETUP_RESET = 24'h000000;
    // Bits the host may write; unused and flag bits are excluded
    localparam logic [23:0] CFG_WR_MASK = 24'h37FF80;

    localparam int CHOP_LO = 20;
    localparam int MC_BIT  = 18;
    localparam int LP_BIT  = 17;
    localparam int RC_BIT  = 16;
    localparam int PTR_LO  = 12;
    localparam int PSS_BIT = 11;
    localparam int PD_BIT  = 10;
    localparam int PSR_BIT = 9;
    localparam int LPM_BIT = 8;
    localparam int RS_BIT  = 7;
    localparam int RV_BIT  = 6;
    localparam int OD_BIT  = 5;
    localparam int OF_BIT  = 4;

    // Chop rate as a divide of the master clock
    localparam logic [7:0] CHOP_DIV_256   = 8'h80;
    localparam logic [7:0] CHOP_DIV_4096  = 8'h08;
    localparam logic [7:0] CHOP_DIV_16384 = 8'h02;
    localparam logic [7:0] CHOP_DIV_1024  = 8'h20;

    localparam int CLK_HZ          = 25_000_000;
    localparam int WAKE_DELAY_MS   = 500;
    localparam int WAKE_CYCLES_DEF = WAKE_DELAY_MS * (CLK_HZ / 1000);
    localparam int PUMP_HALF_DEF   = 64;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_CONV = 3'b010,
        SEQ_HOLD = 3'b100
    } acrc_seq_e;

    typedef enum logic [4:0] {
        PWR_NORMAL  = 5'b00001,
        PWR_REDUCED = 5'b00010,
        PWR_STANDBY = 5'b00100,
        PWR_SLEEP   = 5'b01000,
        PWR_WAKE    = 5'b10000
    } acrc_pwr_e;

    typedef struct packed {
        logic       cmd;
        logic       multi;
        logic       cal;
        logic [3:0] setup;
    } acrc_conv_req_s;

    typedef struct packed {
        logic       start;
        logic       cal;
        logic [3:0] setup;
    } acrc_conv_start_s;

    typedef struct packed {
        logic        busy;
        logic        done;
        logic [31:0] cnt;
    } acrc_tmr_s;

    typedef struct packed {
        logic meta;
        logic sync;
    } acrc_sync_s;

    typedef struct packed {
        logic [23:0]      cfg;
        acrc_seq_e        seq;
        acrc_pwr_e        pwr;
        logic             multi;
        logic             cal;
        logic [3:0]       idx;
        logic             unread;
        acrc_conv_start_s start;
        logic [23:0]      rdata;
        logic             rvalid;
        logic [7:0]       chop_div;
        logic             an_pd;
        logic             flt_halt;
        logic             osc_en;
        logic             reduced;
        logic             pump_drv;
        logic             pump_oe;
        logic             soft_rst;
        logic [1:0]       dflags;
    } acrc_state_s;

endpackage

// >>> logic/acrc_sync.sv
// Two-stage synchroniser for one asynchronous level.
// Assumes the input has no timing relation to clk_in.
`timescale 1ns/1ps
module acrc_sync (
    input  wire logic clk_in,
    input  wire logic nrst_in,
    input  wire logic ce_in,
    input  wire logic async_in,
    output logic      sync_out
);
    import acrc_pkg::*;

    acrc_sync_s st_r;
    acrc_sync_s st_nxt;

    // First stage feeds only the second stage
    always_comb begin
        st_nxt.meta = async_in;
        st_nxt.sync = st_r.meta;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_r <= '0;
        end else if (ce_in) begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.sync;
endmodule

// >>> logic/acrc_timer.sv
// One-shot down counter: done_out pulses COUNT + 1 cycles after start_in.
// Assumes start_in comes from logic on the same clock.
`timescale 1ns/1ps
module acrc_timer #(
    parameter int COUNT = 4
) (
    input  wire logic clk_in,
    input  wire logic nrst_in,
    input  wire logic ce_in,
    input  wire logic start_in,
    output logic      busy_out,
    output logic      done_out
);
    import acrc_pkg::*;

    if (COUNT < 1) begin : g_bad_count
        $error("acrc_timer: COUNT must be at least 1");
    end

    acrc_tmr_s st_r;
    acrc_tmr_s st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (start_in) begin
            st_nxt.busy = 1'b1;
            st_nxt.cnt  = 32'(COUNT - 1);
        end else if (st_r.busy) begin
            if (st_r.cnt == 32'h0) begin
                st_nxt.busy = 1'b0;
                st_nxt.done = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt - 32'h1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_r <= '0;
        end else if (ce_in) begin
            st_r <= st_nxt;
        end
    end

    assign busy_out = st_r.busy;
    assign done_out = st_r.done;
endmodule

// >>> logic/acrc_top.sv
// Configuration register, conversion sequencer and power control.
// Assumes the serial port framer delivers whole 24-bit words as strobes
// on this clock, and the conversion engine answers each start once.
`timescale 1ns/1ps
module acrc_top #(
    parameter bit WIDE24      = 1'b1,
    parameter int WAKE_CYCLES = acrc_pkg::WAKE_CYCLES_DEF,
    parameter int PUMP_HALF   = acrc_pkg::PUMP_HALF_DEF
) (
    input  wire logic                     SYS_CLK_IN,
    input  wire logic                     NRST_IN,
    input  wire logic                     CE_IN,
    input  wire logic                     CFG_WR_IN,
    input  wire logic [23:0]              CFG_WDATA_IN,
    input  wire logic                     CFG_RD_IN,
    input  wire acrc_pkg::acrc_conv_req_s CONV_REQ_IN,
    input  wire logic                     STOP_CMD_IN,
    input  wire logic                     DATA_READ_IN,
    input  wire logic                     CONV_DONE_IN,
    input  wire logic                     CONV_OVR_IN,
    input  wire logic                     OSC_DET_IN,
    output logic [23:0]                   CFG_RDATA_OUT,
    output logic                          CFG_RVALID_OUT,
    output acrc_pkg::acrc_conv_start_s    CONV_START_OUT,
    output logic [7:0]                    CHOP_DIV_OUT,
    output acrc_pkg::acrc_pwr_e           PWR_MODE_OUT,
    output logic                          ANALOG_PD_OUT,
    output logic                          FILTER_HALT_OUT,
    output logic                          OSC_EN_OUT,
    output logic                          REDUCED_OUT,
    output logic                          PUMP_DRV_OUT,
    output logic                          PUMP_OE_OUT,
    output logic                          SOFT_RST_OUT,
    output logic [1:0]                    DATA_FLAGS_OUT
);
    import acrc_pkg::*;

    if (WAKE_CYCLES < 1 || PUMP_HALF < 1) begin : g_bad_param
        $error("acrc_top: delay counts must be at least 1");
    end

    acrc_state_s st_r;
    acrc_state_s st_nxt;
    logic        osc_sync;
    logic        wake_start;
    logic        wake_done;
    logic        pump_busy;
    logic        pump_tick;

    // Oscillation detector is an analog level, not on this clock
    acrc_sync u_osc_sync (
        .clk_in   (SYS_CLK_IN),
        .nrst_in  (NRST_IN),
        .ce_in    (CE_IN),
        .async_in (OSC_DET_IN),
        .sync_out (osc_sync)
    );

    acrc_timer #(
        .COUNT (WAKE_CYCLES)
    ) u_wake_tmr (
        .clk_in   (SYS_CLK_IN),
        .nrst_in  (NRST_IN),
        .ce_in    (CE_IN),
        .start_in (wake_start),
        .busy_out (),
        .done_out (wake_done)
    );

    // Free-running half-period timer for the pump drive
    acrc_timer #(
        .COUNT (PUMP_HALF)
    ) u_pump_tmr (
        .clk_in   (SYS_CLK_IN),
        .nrst_in  (NRST_IN),
        .ce_in    (CE_IN),
        .start_in (!pump_busy),
        .busy_out (pump_busy),
        .done_out (pump_tick)
    );

    always_comb begin
        logic        run_ok;
        logic        rv_set;
        logic        restart;
        logic [3:0]  ptr;
        acrc_pwr_e   run_mode;
        run_ok   = 1'b0;
        rv_set   = 1'b0;
        restart  = 1'b0;
        ptr      = 4'h0;
        run_mode = PWR_NORMAL;

        st_nxt             = st_r;
        st_nxt.start.start = 1'b0;
        st_nxt.rvalid      = 1'b0;

        // Host access to the whole word
        if (CFG_RD_IN) begin
            st_nxt.rdata  = st_r.cfg;
            st_nxt.rvalid = 1'b1;
        end
        if (CFG_WR_IN) begin
            if (st_r.cfg[RS_BIT]) begin
                // Only the reset request bit is taken during reset
                if (!CFG_WDATA_IN[RS_BIT]) begin
                    st_nxt.cfg = CFG_RESET;
                    rv_set     = 1'b1;
                end
            end else if (CFG_WDATA_IN[RS_BIT]) begin
                st_nxt.cfg         = CFG_RESET;
                st_nxt.cfg[RS_BIT] = 1'b1;
                st_nxt.cfg[RV_BIT] = 1'b0;
            end else begin
                // Unused bits are dropped even if the host sends ones
                st_nxt.cfg = (CFG_WDATA_IN & CFG_WR_MASK)
                           | (st_r.cfg & ~CFG_WR_MASK);
            end
        end
        // A completing reset outranks a read clearing the flag
        if (CFG_RD_IN && !rv_set) begin
            st_nxt.cfg[RV_BIT] = 1'b0;
        end

        st_nxt.soft_rst = st_nxt.cfg[RS_BIT];

        // Power mode follows the word; sleep exit waits for the wake timer, not OSC_DET_IN
        if (WIDE24 && st_nxt.cfg[LPM_BIT]) begin
            run_mode = PWR_REDUCED;
        end
        if (st_nxt.cfg[PSR_BIT]) begin
            st_nxt.pwr = st_nxt.cfg[PSS_BIT] ? PWR_SLEEP
                                             : PWR_STANDBY;
        end else if (st_r.pwr == PWR_SLEEP) begin
            st_nxt.pwr = PWR_WAKE;
        end else if (st_r.pwr == PWR_WAKE && !wake_done) begin
            st_nxt.pwr = PWR_WAKE;
        end else begin
            st_nxt.pwr = run_mode;
        end
        st_nxt.an_pd    = st_nxt.pwr inside {PWR_STANDBY, PWR_SLEEP};
        st_nxt.flt_halt = st_nxt.an_pd;
        st_nxt.osc_en   = st_nxt.pwr != PWR_SLEEP;
        st_nxt.reduced  = st_nxt.pwr == PWR_REDUCED;
        run_ok = !st_nxt.soft_rst
               && (st_nxt.pwr inside {PWR_NORMAL, PWR_REDUCED});

        unique case (st_nxt.cfg[CHOP_LO+:2])
            2'h0: st_nxt.chop_div = CHOP_DIV_256;
            2'h1: st_nxt.chop_div = CHOP_DIV_4096;
            2'h2: st_nxt.chop_div = CHOP_DIV_16384;
            2'h3: st_nxt.chop_div = CHOP_DIV_1024;
        endcase

        // Pump floats while disabled, toggles while enabled
        st_nxt.pump_oe = !st_nxt.cfg[PD_BIT];
        if (!st_nxt.pump_oe) begin
            st_nxt.pump_drv = 1'b0;
        end else if (pump_tick) begin
            st_nxt.pump_drv = !st_r.pump_drv;
        end

        // Data read by the host; a new result in the same cycle wins
        if (DATA_READ_IN) begin
            st_nxt.unread = 1'b0;
        end

        ptr = st_nxt.cfg[PTR_LO+:4];
        unique case (st_r.seq)
            SEQ_IDLE: begin
                if (CONV_REQ_IN.cmd && run_ok) begin
                    st_nxt.cal   = CONV_REQ_IN.cal;
                    st_nxt.multi = CONV_REQ_IN.multi
                                 && st_nxt.cfg[MC_BIT]
                                 && !CONV_REQ_IN.cal;
                    st_nxt.idx   = st_nxt.multi ? 4'h0 : CONV_REQ_IN.setup;
                    st_nxt.start.start = 1'b1;
                    st_nxt.seq         = SEQ_CONV;
                end
            end
            SEQ_CONV: begin
                if (CONV_DONE_IN) begin
                    st_nxt.unread = 1'b1;
                    if (st_r.multi && st_r.idx != ptr) begin
                        st_nxt.idx         = st_r.idx + 4'h1;
                        st_nxt.start.start = 1'b1;
                    end else if (st_nxt.cfg[LP_BIT]) begin
                        if (st_nxt.cfg[RC_BIT] && !st_r.cal) begin
                            st_nxt.seq = SEQ_HOLD;
                        end else begin
                            restart = 1'b1;
                        end
                    end else begin
                        st_nxt.seq = SEQ_IDLE;
                    end
                end
            end
            SEQ_HOLD: begin
                // Only a looping sequence can be here
                if (DATA_READ_IN || !st_r.unread) begin
                    restart = 1'b1;
                end
            end
            default: st_nxt.seq = SEQ_IDLE;
        endcase
        if (restart) begin
            st_nxt.seq         = SEQ_CONV;
            st_nxt.idx         = st_r.multi ? 4'h0 : st_r.idx;
            st_nxt.start.start = 1'b1;
        end
        if (STOP_CMD_IN || !run_ok) begin
            st_nxt.seq         = SEQ_IDLE;
            st_nxt.start.start = 1'b0;
        end
        st_nxt.start.setup = st_nxt.idx;
        st_nxt.start.cal   = st_nxt.cal;

        // Error flags; both are cleared while the part sits in reset
        if (st_nxt.soft_rst) begin
            st_nxt.cfg[OF_BIT] = 1'b0;
            st_nxt.cfg[OD_BIT] = 1'b0;
        end else begin
            if (st_r.seq == SEQ_CONV && CONV_DONE_IN) begin
                st_nxt.cfg[OF_BIT] = CONV_OVR_IN;
            end
            st_nxt.cfg[OD_BIT] = osc_sync;
        end
        st_nxt.dflags = WIDE24 ? 2'h0
                               : {st_nxt.cfg[OD_BIT], st_nxt.cfg[OF_BIT]};
    end

    assign wake_start = (st_r.pwr == PWR_SLEEP) && (st_nxt.pwr == PWR_WAKE);

    always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            st_r          <= '0;
            st_r.cfg      <= CFG_RESET;
            st_r.seq      <= SEQ_IDLE;
            st_r.pwr      <= PWR_NORMAL;
            st_r.chop_div <= CHOP_DIV_256;
            st_r.osc_en   <= 1'b1;
            st_r.pump_oe  <= 1'b1;
        end else if (CE_IN) begin
            st_r <= st_nxt;
        end
    end

    assign CFG_RDATA_OUT   = st_r.rdata;
    assign CFG_RVALID_OUT  = st_r.rvalid;
    assign CONV_START_OUT  = st_r.start;
    assign CHOP_DIV_OUT    = st_r.chop_div;
    assign PWR_MODE_OUT    = st_r.pwr;
    assign ANALOG_PD_OUT   = st_r.an_pd;
    assign FILTER_HALT_OUT = st_r.flt_halt;
    assign OSC_EN_OUT      = st_r.osc_en;
    assign REDUCED_OUT     = st_r.reduced;
    assign PUMP_DRV_OUT    = st_r.pump_drv;
    assign PUMP_OE_OUT     = st_r.pump_oe;
    assign SOFT_RST_OUT    = st_r.soft_rst;
    assign DATA_FLAGS_OUT  = st_r.dflags;
endmodule

// >>> verification/acrc_conv_model.sv
// Conversion engine stand-in: answers each start with one done pulse.
// Assumes starts come on the system clock, at most one in flight.
`timescale 1ns/1ps
module acrc_conv_model #(
    parameter int LAT = 5
) (
    input  wire logic clk_in,
    input  wire logic nrst_in,
    input  wire logic start_in,
    input  wire logic ovr_sel_in,
    output logic      done_out,
    output logic      ovr_out
);
    int cnt;
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt <= 0;
            done_out <= 1'b0;
            ovr_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            // Range level means nothing away from done, so keep it moving
            ovr_out <= ~ovr_out;
            if (start_in) begin
                cnt <= LAT;
            end else if (cnt == 1) begin
                done_out <= 1'b1;
                ovr_out <= ovr_sel_in;
                cnt <= 0;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

// >>> verification/acrc_top_asserts.sv
// Port-level checker for the configuration control top.
// Assumes CE_IN stays high and a single clock domain.
`timescale 1ns/1ps
module acrc_top_chk #(
    parameter int WAKE_CYCLES = 20,
    parameter int PUMP_HALF   = 4
) (
    input wire logic                       SYS_CLK_IN,
    input wire logic                       NRST_IN,
    input wire logic                       CE_IN,
    input wire logic                       CFG_WR_IN,
    input wire logic [23:0]                CFG_WDATA_IN,
    input wire logic                       CFG_RD_IN,
    input wire acrc_pkg::acrc_conv_req_s   CONV_REQ_IN,
    input wire logic                       STOP_CMD_IN,
    input wire logic                       DATA_READ_IN,
    input wire logic                       CONV_DONE_IN,
    input wire logic                       CFG_RVALID_OUT,
    input wire acrc_pkg::acrc_conv_start_s CONV_START_OUT,
    input wire logic [7:0]                 CHOP_DIV_OUT,
    input wire acrc_pkg::acrc_pwr_e        PWR_MODE_OUT,
    input wire logic                       ANALOG_PD_OUT,
    input wire logic                       FILTER_HALT_OUT,
    input wire logic                       OSC_EN_OUT,
    input wire logic                       REDUCED_OUT,
    input wire logic                       PUMP_DRV_OUT,
    input wire logic                       PUMP_OE_OUT,
    input wire logic                       SOFT_RST_OUT,
    input wire logic [1:0]                 DATA_FLAGS_OUT
);
    import acrc_pkg::*;
    logic [7:0]  chop_exp_r;
    logic [31:0] wake_r;
    logic [31:0] hold_r;
    logic        drv_prev_r;
    logic        seen_r;
    logic        drv_chg;
    assign drv_chg = PUMP_DRV_OUT != drv_prev_r;
    always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            chop_exp_r <= CHOP_DIV_256;
            wake_r     <= '0;
            hold_r     <= '0;
            drv_prev_r <= 1'b0;
            seen_r     <= 1'b0;
        end else begin
            drv_prev_r <= PUMP_DRV_OUT;
            wake_r <= (PWR_MODE_OUT == PWR_WAKE) ? wake_r + 32'h1 : '0;
            hold_r <= (!PUMP_OE_OUT || drv_chg) ? '0 : hold_r + 32'h1;
            // First edge after enabling has an arbitrary phase
            seen_r <= PUMP_OE_OUT && (seen_r || drv_chg);
            if (CFG_WR_IN && !CFG_WDATA_IN[7]) begin
                case (CFG_WDATA_IN[21:20])
                    2'h0: chop_exp_r <= CHOP_DIV_256;
                    2'h1: chop_exp_r <= CHOP_DIV_4096;
                    2'h2: chop_exp_r <= CHOP_DIV_16384;
                    default: chop_exp_r <= CHOP_DIV_1024;
                endcase
            end
        end
    end
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!NRST_IN);
    sequence s_cfg_wr;
        CE_IN && CFG_WR_IN && !CFG_WDATA_IN[7] && !SOFT_RST_OUT;
    endsequence
    sequence s_quiet;
        !CFG_WR_IN [*2];
    endsequence
    a_read_valid: assert property (
        CE_IN |=> CFG_RVALID_OUT == $past(CFG_RD_IN))
        else $error("read strobe not answered one cycle later");
    a_chop_map: assert property (
        s_cfg_wr ##1 s_quiet |-> CHOP_DIV_OUT == chop_exp_r)
        else $error("chop divide does not match written field");
    a_pump_float: assert property (
        !PUMP_OE_OUT |-> !PUMP_DRV_OUT)
        else $error("pump drive active while pin floats");
    // Timer reloads one cycle after it expires, so a half period is
    // PUMP_HALF + 1 cycles and hold_r reads PUMP_HALF at each toggle
    a_pump_rate: assert property (
        PUMP_OE_OUT && seen_r && drv_chg |-> hold_r == PUMP_HALF)
        else $error("pump drive half period wrong");
    a_sleep_outs: assert property (
        PWR_MODE_OUT == PWR_SLEEP
        |-> !OSC_EN_OUT && ANALOG_PD_OUT && FILTER_HALT_OUT)
        else $error("sleep outputs wrong");
    a_standby_outs: assert property (
        PWR_MODE_OUT == PWR_STANDBY
        |-> OSC_EN_OUT && ANALOG_PD_OUT && FILTER_HALT_OUT)
        else $error("standby outputs wrong");
    a_wake_delay: assert property (
        $fell(PWR_MODE_OUT == PWR_WAKE) |-> wake_r == WAKE_CYCLES + 1)
        else $error("oscillator start-up wait has wrong length");
    a_start_cause: assert property (
        CONV_START_OUT.start |-> $past(CONV_REQ_IN.cmd)
        || $past(CONV_DONE_IN) || $past(DATA_READ_IN))
        else $error("conversion start without a cause");
    a_stop_halts: assert property (
        STOP_CMD_IN ##1 !CONV_REQ_IN.cmd [*4] |-> !CONV_START_OUT.start)
        else $error("conversion started after stop");
    a_srst_enter: assert property (
        CFG_WR_IN && CFG_WDATA_IN[7] && !SOFT_RST_OUT
        |-> ##[1:2] SOFT_RST_OUT)
        else $error("soft reset not entered");
    a_srst_leave: assert property (
        SOFT_RST_OUT && CFG_WR_IN && !CFG_WDATA_IN[7]
        |-> ##[1:2] !SOFT_RST_OUT)
        else $error("soft reset not left");
    a_reduced_mode: assert property (
        REDUCED_OUT == (PWR_MODE_OUT == PWR_REDUCED))
        else $error("reduced output disagrees with mode");
    a_flags_wide: assert property (
        DATA_FLAGS_OUT == 2'h0)
        else $error("data word flags on the wide variant");
endmodule
bind acrc_top acrc_top_chk #(
    .WAKE_CYCLES(WAKE_CYCLES),
    .PUMP_HALF(PUMP_HALF)
) u_chk (
    .SYS_CLK_IN(SYS_CLK_IN), .NRST_IN(NRST_IN), .CE_IN(CE_IN),
    .CFG_WR_IN(CFG_WR_IN), .CFG_WDATA_IN(CFG_WDATA_IN),
    .CFG_RD_IN(CFG_RD_IN), .CONV_REQ_IN(CONV_REQ_IN),
    .STOP_CMD_IN(STOP_CMD_IN), .DATA_READ_IN(DATA_READ_IN),
    .CONV_DONE_IN(CONV_DONE_IN), .CFG_RVALID_OUT(CFG_RVALID_OUT),
    .CONV_START_OUT(CONV_START_OUT), .CHOP_DIV_OUT(CHOP_DIV_OUT),
    .PWR_MODE_OUT(PWR_MODE_OUT), .ANALOG_PD_OUT(ANALOG_PD_OUT),
    .FILTER_HALT_OUT(FILTER_HALT_OUT), .OSC_EN_OUT(OSC_EN_OUT),
    .REDUCED_OUT(REDUCED_OUT), .PUMP_DRV_OUT(PUMP_DRV_OUT),
    .PUMP_OE_OUT(PUMP_OE_OUT), .SOFT_RST_OUT(SOFT_RST_OUT),
    .DATA_FLAGS_OUT(DATA_FLAGS_OUT)
);

// >>> verification/acrc_top_tb_top.sv
// Self-checking bench for the configuration control top.
// Assumes 25 MHz clock, shortened wake and pump counts, CE held high.
`timescale 1ns/1ps
module acrc_top_tb_top;
    import acrc_pkg::*;
    localparam int  WAKE = 20;
    localparam time DLY  = 1ns;
    localparam logic [7:0] CHOP_TAB [4] = '{CHOP_DIV_256, CHOP_DIV_4096,
                                            CHOP_DIV_16384, CHOP_DIV_1024};
    logic             clk;
    logic             nrst;
    logic             wr;
    logic [23:0]      wdata;
    logic             rd;
    acrc_conv_req_s   req;
    logic             stop;
    logic             dread;
    logic             done;
    logic             ovr;
    logic             ovr_sel;
    logic             osc;
    logic [23:0]      rdata;
    logic             rvalid;
    acrc_conv_start_s st;
    logic [7:0]       chop;
    acrc_pwr_e        pwr;
    logic             apd;
    logic             fhalt;
    logic             osc_en;
    logic             reduced;
    logic             poe;
    logic             srst;
    logic [3:0]       starts[$];
    int               errors;
    int               samples_checked;
    acrc_top #(.WAKE_CYCLES(WAKE), .PUMP_HALF(4)) uut (
        .SYS_CLK_IN(clk), .NRST_IN(nrst), .CE_IN(1'b1),
        .CFG_WR_IN(wr), .CFG_WDATA_IN(wdata), .CFG_RD_IN(rd),
        .CONV_REQ_IN(req), .STOP_CMD_IN(stop), .DATA_READ_IN(dread),
        .CONV_DONE_IN(done), .CONV_OVR_IN(ovr), .OSC_DET_IN(osc),
        .CFG_RDATA_OUT(rdata), .CFG_RVALID_OUT(rvalid),
        .CONV_START_OUT(st), .CHOP_DIV_OUT(chop), .PWR_MODE_OUT(pwr),
        .ANALOG_PD_OUT(apd), .FILTER_HALT_OUT(fhalt), .OSC_EN_OUT(osc_en),
        .REDUCED_OUT(reduced), .PUMP_DRV_OUT(), .PUMP_OE_OUT(poe),
        .SOFT_RST_OUT(srst), .DATA_FLAGS_OUT()
    );
    acrc_conv_model #(.LAT(5)) eng (
        .clk_in(clk), .nrst_in(nrst), .start_in(st.start),
        .ovr_sel_in(ovr_sel), .done_out(done), .ovr_out(ovr)
    );
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (st.start === 1'b1) begin
            starts.push_back(st.setup);
        end
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #DLY;
    endtask
    task automatic wr_cfg(input logic [23:0] d);
        tick(1);
        wr = 1'b1;
        wdata = d;
        tick(1);
        wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [23:0] e);
        tick(1);
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        chk(rvalid, 1'b1);
        chk(rdata, e);
    endtask
    task automatic conv(input logic m, input logic [3:0] s,
                        input logic c = 1'b0);
        tick(1);
        req = '{cmd: 1'b1, multi: m, cal: c, setup: s};
        tick(1);
        req.cmd = 1'b0;
    endtask
    task automatic pulse(ref logic s);
        tick(1);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic close_out;
        $display("compared %0d values, %0d wrong", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #(40ns * 5000);
        errors++;
        close_out();
    end
    initial begin
        nrst = 1'b0;
        wr = 1'b0;
        wdata = '0;
        rd = 1'b0;
        req = '0;
        stop = 1'b0;
        dread = 1'b0;
        ovr_sel = 1'b0;
        osc = 1'b0;
        errors = 0;
        samples_checked = 0;
        tick(12);
        nrst = 1'b1;
        chk(pwr, PWR_NORMAL);
        chk(poe, 1'b1);
        rd_chk(CFG_RESET);
        rd_chk(24'h000000);
        $display("test reset finished");
        // Unused bits stay zero; ones on the flag bits must not stick
        wr_cfg(24'h37FF70);
        tick(2);
        chk(pwr, PWR_SLEEP);
        chk({osc_en, apd, fhalt, poe}, 4'h6);
        rd_chk(24'h37FF00);
        wr_cfg(24'h000100);
        tick(2);
        chk(pwr, PWR_WAKE);
        tick(WAKE + 2);
        chk(pwr, PWR_REDUCED);
        chk(reduced, 1'b1);
        wr_cfg(24'h000600);
        tick(2);
        chk(pwr, PWR_STANDBY);
        chk({osc_en, apd, poe}, 3'h6);
        wr_cfg(24'h000000);
        tick(2);
        chk(pwr, PWR_NORMAL);
        for (int i = 0; i < 4; i++) begin
            wr_cfg({2'h0, i[1:0], 20'h0});
            tick(2);
            chk(chop, CHOP_TAB[i]);
        end
        $display("test power and chop finished");
        ovr_sel = 1'b1;
        wr_cfg(24'h042000);
        starts.delete();
        conv(1'b1, 4'h0);
        tick(60);
        chk(starts.size(), 3);
        chk({starts[0], starts[1], starts[2]}, 12'h012);
        rd_chk(24'h042010);
        ovr_sel = 1'b0;
        wr_cfg(24'h002000);
        starts.delete();
        conv(1'b1, 4'h5);
        tick(30);
        chk(starts.size(), 1);
        chk(starts[0], 4'h5);
        rd_chk(24'h002000);
        wr_cfg(24'h030000);
        starts.delete();
        conv(1'b0, 4'h3);
        tick(30);
        chk(starts.size(), 1);
        pulse(dread);
        tick(3);
        chk(starts.size(), 2);
        pulse(stop);
        tick(30);
        chk(starts.size(), 2);
        wr_cfg(24'h010000);
        starts.delete();
        conv(1'b0, 4'h1);
        tick(20);
        conv(1'b0, 4'h1);
        tick(20);
        chk(starts.size(), 2);
        // Calibration loops on one setup and never waits for a read
        wr_cfg(24'h070000);
        starts.delete();
        conv(1'b1, 4'h2, 1'b1);
        tick(20);
        chk(starts.size(), 3);
        chk(starts[2], 4'h2);
        chk(st.cal, 1'b1);
        pulse(stop);
        tick(10);
        $display("test conversions finished");
        wr_cfg(24'h000080);
        tick(2);
        chk(srst, 1'b1);
        rd_chk(24'h000080);
        wr_cfg(24'h100000);
        tick(2);
        chk(srst, 1'b0);
        rd_chk(CFG_RESET);
        rd_chk(24'h000000);
        osc = 1'b1;
        tick(6);
        rd_chk(24'h000020);
        osc = 1'b0;
        tick(6);
        rd_chk(24'h000000);
        $display("test soft reset and flags finished");
        close_out();
    end
endmodule
